// ---- design/spi_frame_config.sv ----
// SPI slave with frame format configuration, fill characters, list mode and Avalon-MM registers
//
// Register access over Avalon-MM was chosen for this implementation.
`timescale 1ns/10ps
module spi_frame_config #(
   parameter int BUF_DEPTH = 16
) (
   input wire logic CLK_SYS_IN,
   input wire logic RESET_IN,
   input wire logic [spi_frame_pkg::ADDR_W-1:0] AVS_ADDRESS_IN,
   input wire logic AVS_READ_IN,
   input wire logic AVS_WRITE_IN,
   input wire logic [31:0] AVS_WRITEDATA_IN,
   output logic [31:0] AVS_READDATA_OUT,
   output logic AVS_WAITREQUEST_OUT,
   input wire logic SPI_SCK_IN,
   input wire logic SPI_CS_N_IN,
   input wire logic SPI_MOSI_IN,
   output logic SPI_MISO_OUT,
   output logic SPI_MISO_OE_OUT
);

   localparam int IDX_W = $clog2(BUF_DEPTH);
   localparam int POS_W = spi_frame_pkg::COUNT_W + 3;
   localparam logic [spi_frame_pkg::ADDR_W-1:0] BUF_SPAN = spi_frame_pkg::ADDR_W'(BUF_DEPTH * 4);

   // ----------------------------------------------------------------
   // System domain state
   // ----------------------------------------------------------------
   logic [1:0] csn_sync_r;
   logic csn_prev_r;
   logic wait_r, wait_nxt;
   logic [31:0] rdata_r, rdata_nxt;
   logic list_r, list_nxt;
   spi_frame_pkg::frame_cfg_t cfg_r, cfg_nxt;
   logic [7:0] ign_fill_r, ign_fill_nxt, ovr_fill_r, ovr_fill_nxt;
   logic [IDX_W-1:0] ptr_r, ptr_nxt;
   logic [spi_frame_pkg::COUNT_W-1:0] maxcnt_r, maxcnt_nxt;
   logic ready_r, ready_nxt;
   logic granted_r, granted_nxt;
   logic [spi_frame_pkg::COUNT_W-1:0] amount_r, amount_nxt;
   logic [spi_frame_pkg::COUNT_W-1:0] start_cnt_r, start_cnt_nxt;
   logic [7:0] rx_r, rx_nxt;
   logic [7:0] buf_r [BUF_DEPTH], buf_nxt [BUF_DEPTH];

   // ----------------------------------------------------------------
   // Link domain state
   // ----------------------------------------------------------------
   logic [2:0] bit_cnt_r, bit_cnt_nxt;
   logic [spi_frame_pkg::COUNT_W-1:0] bytes_total_r, bytes_total_nxt;
   logic [7:0] rx_shift_r, rx_shift_nxt, rx_last_r, rx_last_nxt;
   logic [POS_W-1:0] shift_cnt_r;

   logic csn_s, quiet, frame_start, frame_end;
   logic wr_ok, buf_hit, tx_valid, miso_bit;
   logic sck_lead, sample_clk, frame_rst;
   logic [spi_frame_pkg::ADDR_W-1:0] buf_word;
   logic [IDX_W-1:0] buf_idx, ptr_step, tx_slot;
   logic [spi_frame_pkg::COUNT_W-1:0] byte_diff, amount_calc, tx_byte_idx;
   logic [POS_W-1:0] tx_pos;
   logic [2:0] tx_bit;
   logic [7:0] tx_char;

   // ----------------------------------------------------------------
   // Chip select synchroniser and frame edges
   // ----------------------------------------------------------------
   always_ff @(posedge CLK_SYS_IN)
   begin
      if (RESET_IN)
      begin
         csn_sync_r <= 2'h3;
         csn_prev_r <= 1'b1;
      end
      else
      begin
         csn_sync_r <= {csn_sync_r[0], SPI_CS_N_IN};
         csn_prev_r <= csn_sync_r[1];
      end
   end

   assign csn_s = csn_sync_r[1];
   assign quiet = csn_s & csn_prev_r;
   assign frame_start = csn_prev_r & ~csn_s;
   assign frame_end = ~csn_prev_r & csn_s;

   assign wr_ok = AVS_WRITE_IN & ~wait_r;
   assign buf_word = AVS_ADDRESS_IN - spi_frame_pkg::OFF_TX_BUFFER;
   assign buf_hit = (AVS_ADDRESS_IN >= spi_frame_pkg::OFF_TX_BUFFER) && (buf_word < BUF_SPAN);
   assign buf_idx = buf_word[IDX_W+1:2];
   // Over-read bytes and a trailing partial byte are not counted as transmitted
   assign byte_diff = bytes_total_r - start_cnt_r;
   assign amount_calc = (byte_diff > maxcnt_r) ? maxcnt_r : byte_diff; // [RULE7]
   assign ptr_step = maxcnt_r[IDX_W-1:0];

   // ----------------------------------------------------------------
   // Register file and transaction bookkeeping
   // ----------------------------------------------------------------
   always_comb
   begin
      wait_nxt = ~((AVS_READ_IN | AVS_WRITE_IN) & wait_r);
      rdata_nxt = rdata_r;
      list_nxt = list_r;
      cfg_nxt = cfg_r;
      ign_fill_nxt = ign_fill_r;
      ovr_fill_nxt = ovr_fill_r;
      ptr_nxt = ptr_r;
      maxcnt_nxt = maxcnt_r;
      ready_nxt = ready_r;
      granted_nxt = granted_r;
      amount_nxt = amount_r;
      start_cnt_nxt = start_cnt_r;
      rx_nxt = rx_r;
      buf_nxt = buf_r;
      // Grant is frozen while a frame runs, the link side reads it quasi-statically
      if (quiet)
         granted_nxt = ready_r;
      if (frame_start)
         start_cnt_nxt = bytes_total_r;
      if (frame_end)
      begin
         rx_nxt = rx_last_r;
         if (granted_r)
         begin
            amount_nxt = amount_calc; // [RULE7]
            ready_nxt = 1'b0;
            if (list_r == spi_frame_pkg::LIST_CONSECUTIVE)
               ptr_nxt = ptr_r + ptr_step; // [RULE6]
         end
      end
      if (AVS_READ_IN && wait_r)
      begin
         rdata_nxt = spi_frame_pkg::RESET_WORD;
         if (buf_hit)
            rdata_nxt[7:0] = buf_r[buf_idx];
         case (AVS_ADDRESS_IN)
            spi_frame_pkg::OFF_BYTE_COUNT: rdata_nxt[spi_frame_pkg::COUNT_W-1:0] = amount_r;
            spi_frame_pkg::OFF_LIST_MODE: rdata_nxt[0] = list_r;
            spi_frame_pkg::OFF_FRAME_CFG: rdata_nxt[2:0] = cfg_r;
            spi_frame_pkg::OFF_IGNORED_FILL: rdata_nxt[7:0] = ign_fill_r;
            spi_frame_pkg::OFF_OVERREAD_FILL: rdata_nxt[7:0] = ovr_fill_r;
            spi_frame_pkg::OFF_BUF_POINTER: rdata_nxt[IDX_W-1:0] = ptr_r;
            spi_frame_pkg::OFF_BUF_LENGTH: rdata_nxt[spi_frame_pkg::COUNT_W-1:0] = maxcnt_r;
            spi_frame_pkg::OFF_GRANT_CTRL: rdata_nxt[spi_frame_pkg::GRANT_READY_BIT] = ready_r;
            spi_frame_pkg::OFF_LINK_STATUS:
            begin
               rdata_nxt[spi_frame_pkg::STATUS_ACTIVE_BIT] = ~csn_s;
               rdata_nxt[spi_frame_pkg::STATUS_RX_LSB+:8] = rx_r;
            end
            default: ;
         endcase
      end
      // Setting the grant wins over the hardware release in the same cycle
      if (wr_ok && AVS_ADDRESS_IN == spi_frame_pkg::OFF_GRANT_CTRL)
         ready_nxt = AVS_WRITEDATA_IN[spi_frame_pkg::GRANT_READY_BIT];
      // Frame-static settings ignore writes while chip select is low
      if (wr_ok && quiet)
      begin
         if (buf_hit)
            buf_nxt[buf_idx] = AVS_WRITEDATA_IN[7:0];
         case (AVS_ADDRESS_IN)
            spi_frame_pkg::OFF_LIST_MODE: list_nxt = AVS_WRITEDATA_IN[0];
            spi_frame_pkg::OFF_FRAME_CFG: cfg_nxt = AVS_WRITEDATA_IN[2:0];
            spi_frame_pkg::OFF_IGNORED_FILL: ign_fill_nxt = AVS_WRITEDATA_IN[7:0];
            spi_frame_pkg::OFF_OVERREAD_FILL: ovr_fill_nxt = AVS_WRITEDATA_IN[7:0];
            spi_frame_pkg::OFF_BUF_POINTER: ptr_nxt = AVS_WRITEDATA_IN[IDX_W-1:0];
            spi_frame_pkg::OFF_BUF_LENGTH: maxcnt_nxt = AVS_WRITEDATA_IN[spi_frame_pkg::COUNT_W-1:0];
            default: ;
         endcase
      end
   end

   always_ff @(posedge CLK_SYS_IN)
   begin
      if (RESET_IN)
      begin
         wait_r <= 1'b1;
         rdata_r <= spi_frame_pkg::RESET_WORD;
         list_r <= spi_frame_pkg::LIST_DISABLED;
         cfg_r <= '0;
         ign_fill_r <= spi_frame_pkg::RESET_CHAR;
         ovr_fill_r <= spi_frame_pkg::RESET_CHAR;
         ptr_r <= '0;
         maxcnt_r <= '0;
         ready_r <= 1'b0;
         granted_r <= 1'b0;
         amount_r <= '0;
         start_cnt_r <= '0;
         rx_r <= spi_frame_pkg::RESET_CHAR;
         buf_r <= '{default: spi_frame_pkg::RESET_CHAR};
      end
      else
      begin
         wait_r <= wait_nxt;
         rdata_r <= rdata_nxt;
         list_r <= list_nxt;
         cfg_r <= cfg_nxt;
         ign_fill_r <= ign_fill_nxt;
         ovr_fill_r <= ovr_fill_nxt;
         ptr_r <= ptr_nxt;
         maxcnt_r <= maxcnt_nxt;
         ready_r <= ready_nxt;
         granted_r <= granted_nxt;
         amount_r <= amount_nxt;
         start_cnt_r <= start_cnt_nxt;
         rx_r <= rx_nxt;
         buf_r <= buf_nxt;
      end
   end

   assign AVS_READDATA_OUT = rdata_r;
   assign AVS_WAITREQUEST_OUT = wait_r;

   // ----------------------------------------------------------------
   // Link clocks: polarity gives the leading edge, phase picks the sample edge
   // ----------------------------------------------------------------
   assign sck_lead = SPI_SCK_IN ^ cfg_r.clock_polarity_select; // [RULE3]
   assign sample_clk = sck_lead ^ cfg_r.clock_phase_select; // [RULE2]
   assign frame_rst = SPI_CS_N_IN | RESET_IN;

   always_comb
   begin
      bit_cnt_nxt = bit_cnt_r + 3'h1;
      if (cfg_r.low_bit_leading == spi_frame_pkg::HIGH_BIT_LEADING)
         rx_shift_nxt = {rx_shift_r[6:0], SPI_MOSI_IN};
      else
         rx_shift_nxt = {SPI_MOSI_IN, rx_shift_r[7:1]};
      bytes_total_nxt = bytes_total_r;
      rx_last_nxt = rx_last_r;
      if (bit_cnt_r == 3'h7)
      begin
         bytes_total_nxt = bytes_total_r + 1'b1;
         rx_last_nxt = rx_shift_nxt;
      end
   end

   always_ff @(posedge sample_clk or posedge frame_rst)
   begin
      if (frame_rst)
         bit_cnt_r <= 3'h0;
      else
         bit_cnt_r <= bit_cnt_nxt; // [RULE2]
   end

   // Totals survive chip select so the system side can read them after the frame
   always_ff @(posedge sample_clk or posedge RESET_IN)
   begin
      if (RESET_IN)
      begin
         bytes_total_r <= '0;
         rx_shift_r <= spi_frame_pkg::RESET_CHAR;
         rx_last_r <= spi_frame_pkg::RESET_CHAR;
      end
      else
      begin
         bytes_total_r <= bytes_total_nxt;
         rx_shift_r <= rx_shift_nxt;
         rx_last_r <= rx_last_nxt;
      end
   end

   always_ff @(negedge sample_clk or posedge frame_rst)
   begin
      if (frame_rst)
         shift_cnt_r <= '0;
      else
         shift_cnt_r <= shift_cnt_r + 1'b1; // [RULE2]
   end

   // ----------------------------------------------------------------
   // Character selection and output bit
   // ----------------------------------------------------------------
   // Phase 1 shifts on the leading edge, so nothing is valid before the first one
   assign tx_pos = cfg_r.clock_phase_select ? shift_cnt_r - 1'b1 : shift_cnt_r; // [RULE2]
   assign tx_valid = ~(cfg_r.clock_phase_select && shift_cnt_r == '0);
   assign tx_byte_idx = tx_pos[POS_W-1:3];
   assign tx_bit = tx_pos[2:0];
   assign tx_slot = ptr_r + tx_byte_idx[IDX_W-1:0];

   always_comb
   begin
      if (!granted_r)
         tx_char = ign_fill_r; // [RULE4]
      else if (tx_byte_idx >= maxcnt_r)
         tx_char = ovr_fill_r; // [RULE5]
      else
         tx_char = buf_r[tx_slot];
   end

   assign miso_bit = cfg_r.low_bit_leading ? tx_char[tx_bit] : tx_char[3'h7 - tx_bit]; // [RULE1]
   // Driven straight from the shift position; a register here would cost the first bit in phase 0
   assign SPI_MISO_OUT = ~SPI_CS_N_IN & tx_valid & miso_bit;
   assign SPI_MISO_OE_OUT = ~SPI_CS_N_IN;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   property p_order;
      @(posedge CLK_SYS_IN) disable iff (RESET_IN) (!SPI_CS_N_IN && tx_valid && tx_bit == 3'h0)
         |-> SPI_MISO_OUT == (cfg_r.low_bit_leading ? tx_char[0] : tx_char[7]);
   endproperty
   a_order: assert property (p_order) else $error("first bit of a character has the wrong order"); // [RULE1]
   property p_sample_advance;
      @(posedge sample_clk) disable iff (frame_rst) 1 |=> bit_cnt_r == $past(bit_cnt_r) + 3'h1;
   endproperty
   a_sample_advance: assert property (p_sample_advance) else $error("sample edge did not advance bit"); // [RULE2]
   // A polarity change while deselected makes a stray edge that must not count
   property p_idle_level;
      @(posedge CLK_SYS_IN) disable iff (RESET_IN) SPI_CS_N_IN
         |-> bit_cnt_r == 3'h0 && shift_cnt_r == '0 && !SPI_MISO_OE_OUT && !SPI_MISO_OUT;
   endproperty
   a_idle_level: assert property (p_idle_level) else $error("serial edge counted while deselected"); // [RULE3]
   property p_ignored_fill;
      @(posedge CLK_SYS_IN) disable iff (RESET_IN) (!SPI_CS_N_IN && !granted_r) |-> tx_char == ign_fill_r;
   endproperty
   a_ignored_fill: assert property (p_ignored_fill) else $error("ignored frame not sending fill character"); // [RULE4]
   property p_overread_fill;
      @(posedge CLK_SYS_IN) disable iff (RESET_IN)
         (!SPI_CS_N_IN && granted_r && tx_byte_idx >= maxcnt_r) |-> tx_char == ovr_fill_r;
   endproperty
   a_overread_fill: assert property (p_overread_fill) else $error("over-read byte not sending fill"); // [RULE5]
   property p_list_advance;
      @(posedge CLK_SYS_IN) disable iff (RESET_IN)
         (frame_end && granted_r && list_r) |=> ptr_r == $past(ptr_r) + $past(ptr_step);
   endproperty
   a_list_advance: assert property (p_list_advance) else $error("buffer pointer did not advance"); // [RULE6]
   property p_list_hold;
      @(posedge CLK_SYS_IN) disable iff (RESET_IN) (frame_end && !list_r) |=> $stable(ptr_r);
   endproperty
   a_list_hold: assert property (p_list_hold) else $error("buffer pointer moved with lists disabled"); // [RULE6]
   property p_count;
      @(posedge CLK_SYS_IN) disable iff (RESET_IN)
         (frame_end && granted_r) |=> amount_r == $past(amount_calc) ##1 $stable(amount_r);
   endproperty
   a_count: assert property (p_count) else $error("transmitted byte count not recorded"); // [RULE7]
   property p_count_ignored;
      @(posedge CLK_SYS_IN) disable iff (RESET_IN) (frame_end && !granted_r) |=> $stable(amount_r);
   endproperty
   a_count_ignored: assert property (p_count_ignored) else $error("ignored frame changed byte count"); // [RULE7]
   c_granted: cover property (@(posedge CLK_SYS_IN) disable iff (RESET_IN) frame_end && granted_r);
   c_ignored: cover property (@(posedge CLK_SYS_IN) disable iff (RESET_IN) frame_end && !granted_r);
   c_overread: cover property (@(posedge CLK_SYS_IN) disable iff (RESET_IN)
      !SPI_CS_N_IN && granted_r && tx_byte_idx >= maxcnt_r);
   c_list: cover property (@(posedge CLK_SYS_IN) disable iff (RESET_IN) frame_end && granted_r && list_r);

endmodule

// ---- design/spi_frame_pkg.sv ----
// Constants, register map and field layout of the SPI slave frame configuration block
// Summary of operation
// RULE1: Each character is shifted out high bit first when the bit order field is 0 and low bit first when it is 1.
// RULE2: With clock phase 0 data is sampled on the leading edge and shifted on the trailing edge, with 1 the reverse.
// RULE3: Clock polarity 0 treats the serial clock as active high, 1 as active low, which defines leading and trailing.
// RULE4: An ignored transaction shifts out the 8-bit ignored fill character instead of buffer data.
// RULE5: Every byte clocked beyond the transmit buffer length shifts out the 8-bit over-read fill character.
// RULE6: List mode 0 disables list handling; 1 advances the buffer pointer to the next buffer after each transaction; code advances only after granted ones.
// RULE7: After each granted transaction a read-only register holds the number of bytes actually transmitted.
package spi_frame_pkg;

   // ----------------------------------------------------------------
   // Register map, byte addresses
   // ----------------------------------------------------------------
   localparam int ADDR_W = 12;
   localparam logic [ADDR_W-1:0] OFF_BYTE_COUNT = 12'h54C;
   localparam logic [ADDR_W-1:0] OFF_LIST_MODE = 12'h550;
   localparam logic [ADDR_W-1:0] OFF_FRAME_CFG = 12'h554;
   localparam logic [ADDR_W-1:0] OFF_IGNORED_FILL = 12'h55C;
   localparam logic [ADDR_W-1:0] OFF_OVERREAD_FILL = 12'h5C0;
   localparam logic [ADDR_W-1:0] OFF_BUF_POINTER = 12'h5E0;
   localparam logic [ADDR_W-1:0] OFF_BUF_LENGTH = 12'h5E4;
   localparam logic [ADDR_W-1:0] OFF_GRANT_CTRL = 12'h5E8;
   localparam logic [ADDR_W-1:0] OFF_LINK_STATUS = 12'h5EC;
   localparam logic [ADDR_W-1:0] OFF_TX_BUFFER = 12'h600;

   // ----------------------------------------------------------------
   // Field positions, widths and reset values
   // ----------------------------------------------------------------
   localparam int CFG_ORDER_BIT = 0;
   localparam int CFG_PHASE_BIT = 1;
   localparam int CFG_POLARITY_BIT = 2;
   localparam int GRANT_READY_BIT = 0;
   localparam int STATUS_ACTIVE_BIT = 0;
   localparam int STATUS_RX_LSB = 8;
   localparam int COUNT_W = 10;
   localparam logic [31:0] RESET_WORD = 32'h0000_0000;
   localparam logic [7:0] RESET_CHAR = 8'h00;
   localparam logic LIST_DISABLED = 1'b0;
   localparam logic LIST_CONSECUTIVE = 1'b1;
   localparam logic HIGH_BIT_LEADING = 1'b0;

   typedef struct packed {
      logic clock_polarity_select;
      logic clock_phase_select;
      logic low_bit_leading;
   } frame_cfg_t;

endpackage

// ---- sim/spi_master_model.sv ----
// Behavioural SPI master that clocks three-byte frames into the slave and reports each byte it reads back
`timescale 1ns/10ps
module spi_master_model (
   output logic sck_out,
   output logic cs_n_out,
   output logic mosi_out,
   input wire logic miso_in,
   output logic [7:0] rx_out,
   output logic rx_stb_out
);
   initial
   begin
      sck_out = 1'b0;
      cs_n_out = 1'b1;
      mosi_out = 1'b0;
      rx_out = 8'h00;
      rx_stb_out = 1'b0;
   end

   // ----------------------------------------------------------------
   // One frame; mode bit 0 low bit first, bit 1 phase, bit 2 polarity
   // ----------------------------------------------------------------
   task automatic frame(input logic [2:0] mode, input logic [23:0] tx);
      logic [7:0] b;
      logic [7:0] r;
      int j;
      sck_out = mode[2];
      #400;
      cs_n_out = 1'b0;
      // Setup of four system cycles, one beyond the three needed for the select to be seen before any edge
      #400;
      for (int k = 0; k < 3; k++)
      begin
         b = tx[23-8*k -: 8];
         for (int i = 0; i < 8; i++)
         begin
            j = mode[0] ? i : 7 - i;
            if (!mode[1])
               mosi_out = b[j];
            // Read just before the sample edge, once the slave's shift has settled
            #3;
            if (!mode[1])
               r[j] = miso_in;
            sck_out = ~sck_out;
            if (mode[1])
               mosi_out = b[j];
            #3;
            if (mode[1])
               r[j] = miso_in;
            sck_out = ~sck_out;
         end
         rx_out = r;
         rx_stb_out = 1'b1;
         #1;
         rx_stb_out = 1'b0;
      end
      #3;
      cs_n_out = 1'b1;
      // Released data line must not keep the last value
      mosi_out = ~mosi_out;
      #400;
   endtask
endmodule

// ---- sim/test_spi_frame_config.sv ----
// Self-checking bench: registers over Avalon-MM and SPI frames from a master model
`timescale 1ns/10ps
`define CHECK(what, exp, got) begin n_compared++; if ((got) !== (exp)) begin num_errors++; \
   $display("unexpected %s: expected %h, seen %h", what, exp, got); end end
module test_spi_frame_config;
   logic CLK_SYS_IN;
   logic RESET_IN;
   logic [11:0] addr;
   logic rd;
   logic wr;
   logic [31:0] wdata;
   logic [31:0] rdata;
   logic wait_req;
   logic sck, cs_n, mosi, miso, miso_oe, rx_stb;
   logic [7:0] rx, exp_b, ign_c, ovr_c, bv;
   logic [43:0] note;
   logic [43:0] reg_q[$];
   logic [7:0] spi_q[$];
   logic [3:0] ptr, len, idx;
   logic [23:0] tx;
   int num_errors = 0;
   int n_compared = 0;

   spi_frame_config #(.BUF_DEPTH(16)) spi_frame_config_inst (.CLK_SYS_IN(CLK_SYS_IN), .RESET_IN(RESET_IN),
      .AVS_ADDRESS_IN(addr), .AVS_READ_IN(rd), .AVS_WRITE_IN(wr), .AVS_WRITEDATA_IN(wdata),
      .AVS_READDATA_OUT(rdata), .AVS_WAITREQUEST_OUT(wait_req), .SPI_SCK_IN(sck), .SPI_CS_N_IN(cs_n),
      .SPI_MOSI_IN(mosi), .SPI_MISO_OUT(miso), .SPI_MISO_OE_OUT(miso_oe));
   spi_master_model spi_master_model_inst (.sck_out(sck), .cs_n_out(cs_n), .mosi_out(mosi), .miso_in(miso),
      .rx_out(rx), .rx_stb_out(rx_stb));

   initial
   begin
      CLK_SYS_IN = 1'b0;
      forever #50 CLK_SYS_IN = ~CLK_SYS_IN;
   end

   // ----------------------------------------------------------------
   // Closing report and hang guard
   // ----------------------------------------------------------------
   task automatic end_of_test();
      $display("compared %0d, mismatches %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   initial
   begin
      // Whole run needs well under two thousand cycles
      repeat (20000) @(posedge CLK_SYS_IN);
      num_errors++;
      end_of_test();
   end

   // ----------------------------------------------------------------
   // Result watchers take the oldest expectation off each queue
   // ----------------------------------------------------------------
   always @(posedge CLK_SYS_IN)
   begin
      if (rd === 1'b1 && wait_req === 1'b0)
      begin
         `CHECK("read queue filled", 1'b1, reg_q.size() != 0)
         note = reg_q.pop_front();
         `CHECK($sformatf("register %h", note[43:32]), note[31:0], rdata)
      end
   end

   always @(posedge rx_stb)
   begin
      `CHECK("spi queue filled", 1'b1, spi_q.size() != 0)
      exp_b = spi_q.pop_front();
      `CHECK("spi byte", exp_b, rx)
      `CHECK("miso enable", 1'b1, miso_oe)
   end

   // ----------------------------------------------------------------
   // Avalon-MM master: hold the request until waitrequest is seen low
   // ----------------------------------------------------------------
   task automatic bus(input logic is_rd, input logic [11:0] a, input logic [31:0] d);
      int t;
      @(posedge CLK_SYS_IN);
      addr <= a;
      wdata <= d;
      rd <= is_rd;
      wr <= !is_rd;
      t = 0;
      do
      begin
         @(posedge CLK_SYS_IN);
         t++;
      end
      while (wait_req !== 1'b0 && t < 50);
      if (t >= 50)
         `CHECK("bus answer", 1'b0, 1'b1)
      rd <= 1'b0;
      wr <= 1'b0;
   endtask

   task automatic wr_reg(input logic [11:0] a, input logic [31:0] d);
      bus(1'b0, a, d);
   endtask

   task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
      reg_q.push_back({a, e});
      bus(1'b1, a, 32'h0000_0000);
   endtask

   initial
   begin
      RESET_IN = 1'b1;
      rd = 1'b0;
      wr = 1'b0;
      addr = 12'h000;
      wdata = 32'h0000_0000;
      void'($urandom(32'h213F));
      repeat (8) @(posedge CLK_SYS_IN);
      RESET_IN <= 1'b0;
      rd_chk(spi_frame_pkg::OFF_LIST_MODE, 32'h0000_0000);
      rd_chk(spi_frame_pkg::OFF_FRAME_CFG, 32'h0000_0000);
      rd_chk(spi_frame_pkg::OFF_IGNORED_FILL, 32'h0000_0000);
      rd_chk(spi_frame_pkg::OFF_OVERREAD_FILL, 32'h0000_0000);
      rd_chk(spi_frame_pkg::OFF_BYTE_COUNT, 32'h0000_0000);
      rd_chk(12'h004, 32'h0000_0000);
      $display("test reset_values done");
      ign_c = 8'($urandom);
      ovr_c = 8'($urandom);
      wr_reg(spi_frame_pkg::OFF_IGNORED_FILL, {24'hFFFF_FF, ign_c});
      wr_reg(spi_frame_pkg::OFF_OVERREAD_FILL, {24'hA5A5_A5, ovr_c});
      wr_reg(spi_frame_pkg::OFF_FRAME_CFG, 32'hFFFF_FFF5);
      wr_reg(spi_frame_pkg::OFF_LIST_MODE, 32'hFFFF_FFFF);
      wr_reg(spi_frame_pkg::OFF_BYTE_COUNT, 32'h0000_03FF);
      rd_chk(spi_frame_pkg::OFF_IGNORED_FILL, {24'h0, ign_c});
      rd_chk(spi_frame_pkg::OFF_OVERREAD_FILL, {24'h0, ovr_c});
      rd_chk(spi_frame_pkg::OFF_FRAME_CFG, 32'h0000_0005);
      rd_chk(spi_frame_pkg::OFF_LIST_MODE, 32'h0000_0001);
      rd_chk(spi_frame_pkg::OFF_BYTE_COUNT, 32'h0000_0000);
      $display("test register_access done");
      // Every order, phase and polarity combination, list mode on for odd modes
      for (int m = 0; m < 8; m++)
      begin
         ptr = 4'($urandom);
         len = 4'(1 + $urandom % 3);
         tx = 24'($urandom);
         wr_reg(spi_frame_pkg::OFF_FRAME_CFG, {29'h0, 3'(m)});
         wr_reg(spi_frame_pkg::OFF_LIST_MODE, {31'h0, m[0]});
         wr_reg(spi_frame_pkg::OFF_BUF_POINTER, {28'h0, ptr});
         wr_reg(spi_frame_pkg::OFF_BUF_LENGTH, {28'h0, len});
         for (int k = 0; k < 3; k++)
         begin
            bv = 8'($urandom);
            idx = ptr + 4'(k);
            wr_reg(spi_frame_pkg::OFF_TX_BUFFER + {6'h0, idx, 2'b00}, {24'h0, bv});
            spi_q.push_back((k < len) ? bv : ovr_c);
         end
         wr_reg(spi_frame_pkg::OFF_GRANT_CTRL, 32'h0000_0001);
         spi_master_model_inst.frame(3'(m), tx);
         `CHECK("miso released", 2'b00, {miso_oe, miso})
         rd_chk(spi_frame_pkg::OFF_BYTE_COUNT, {28'h0, len});
         rd_chk(spi_frame_pkg::OFF_BUF_POINTER, {28'h0, m[0] ? ptr + len : ptr});
         rd_chk(spi_frame_pkg::OFF_LINK_STATUS, {16'h0, tx[7:0], 8'h00});
         rd_chk(spi_frame_pkg::OFF_GRANT_CTRL, 32'h0000_0000);
      end
      $display("test frame_modes done");
      // Grant was cleared by hardware, so this frame is ignored
      wr_reg(spi_frame_pkg::OFF_FRAME_CFG, 32'h0000_0000);
      repeat (3) spi_q.push_back(ign_c);
      fork
         spi_master_model_inst.frame(3'h0, 24'($urandom));
         begin
            #600;
            wr_reg(spi_frame_pkg::OFF_FRAME_CFG, 32'h0000_0007);
         end
      join
      rd_chk(spi_frame_pkg::OFF_FRAME_CFG, 32'h0000_0000);
      rd_chk(spi_frame_pkg::OFF_BYTE_COUNT, {28'h0, len});
      $display("test ignored_frame done");
      `CHECK("spi queue drained", 0, spi_q.size())
      end_of_test();
   end
endmodule
